// [include/parm_pkg.sv]
// Shared constants and types for the secret-code gate and its terminal end
package parm_pkg;
	localparam int APP_W        = 2;
	localparam int NUM_APPS     = 4;
	localparam int CODE_W       = 32;
	localparam logic [1:0] MAX_WRONG = 2'h3;
	localparam logic [CODE_W-1:0] CODE_RESET   = 32'h00001234;
	localparam logic [CODE_W-1:0] UNBLK_RESET  = 32'h12345678;
	// Software register offsets of the terminal end
	localparam logic [3:0] REG_CMD      = 4'h0;
	localparam logic [3:0] REG_CODE     = 4'h1;
	localparam logic [3:0] REG_NEWCODE  = 4'h2;
	localparam logic [3:0] REG_RESULT   = 4'h3;
	localparam logic [3:0] REG_IRQSTAT  = 4'h4;
	localparam logic [3:0] REG_IRQMASK  = 4'h5;
	localparam logic [3:0] REG_APPSTATE = 4'h6;
	// Field positions
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_APP_LSB  = 4;
	localparam int RES_DONE     = 0;
	localparam int RES_OK       = 1;
	localparam int RES_LOCAL    = 2;
	localparam int ST_BLOCKED   = 0;
	localparam int ST_ENABLED   = 1;
	localparam int ST_ALLOWED   = 2;
	localparam int ST_UBLOCKED  = 3;
	localparam int ST_RIGHT     = 4;
	localparam int IRQ_DONE     = 0;
	localparam int IRQ_FAIL     = 1;
	localparam int IRQ_BLOCK    = 2;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_VERIFY,
		OP_CHANGE,
		OP_DISABLE,
		OP_ENABLE,
		OP_UNBLOCK,
		OP_ABORT
	} parm_op_t;
endpackage

// [include/parm_if.sv]
// Card command link between terminal end and card end
`timescale 1ns/100ps
`default_nettype none
interface parm_if
	import parm_pkg::*;
	();
	logic                  req;
	parm_op_t              op;
	logic [APP_W-1:0]      app;
	logic [CODE_W-1:0]     code;
	logic [CODE_W-1:0]     newCode;
	logic                  done;
	logic                  ok;
	logic [APP_W-1:0]      stApp;
	logic                  stBlocked;
	logic                  stEnabled;
	logic                  stAllowed;
	logic                  stUnblkBlocked;
	logic                  stRight;
	modport card (
		input  req, op, app, code, newCode, stApp,
		output done, ok, stBlocked, stEnabled, stAllowed, stUnblkBlocked,
		stRight
	);
	modport term (
		output req, op, app, code, newCode, stApp,
		input  done, ok, stBlocked, stEnabled, stAllowed, stUnblkBlocked,
		stRight
	);
endinterface
`default_nettype wire

// [rtl/parm_card.sv]
// Card end: stored codes, indicators, wrong-count and access rights
`timescale 1ns/100ps
`default_nettype none
module parm_card
	import parm_pkg::*;
	#(
	parameter logic [NUM_APPS-1:0] ALLOW_ENDIS = '1
	)(
	// Clock and reset
	input  wire logic clock,
	input  wire logic resetn,
	// Link to terminal
	parm_if.card      lnk,
	// Session control
	input  wire logic sessionEnd,
	input  wire logic [parm_pkg::NUM_APPS-1:0] unblkKeyBlocked
	);
	import parm_pkg::*;

	logic [CODE_W-1:0] storedCode [NUM_APPS];
	logic [CODE_W-1:0] unblkKey   [NUM_APPS];
	logic [NUM_APPS-1:0] blocked;
	logic [NUM_APPS-1:0] enabled;
	logic [NUM_APPS-1:0] right;
	logic [1:0] wrongCnt [NUM_APPS];
	logic       match;
	logic       keyMatch;
	logic       codeCmd;
	logic       success;
	logic       wrongNow;

	assign match    = lnk.code == storedCode[lnk.app];
	assign keyMatch = lnk.code == unblkKey[lnk.app];
	assign codeCmd  = lnk.op inside {OP_VERIFY, OP_CHANGE, OP_DISABLE,
		OP_ENABLE};

	// Outcome of the presented command
	always_comb
	begin
		success = 1'b0;
		case (lnk.op)
			OP_VERIFY:  success = match && !blocked[lnk.app];
			OP_CHANGE:  success = match && !blocked[lnk.app];
			OP_DISABLE: success = match && !blocked[lnk.app]
				&& ALLOW_ENDIS[lnk.app];
			OP_ENABLE:  success = match && !blocked[lnk.app]
				&& ALLOW_ENDIS[lnk.app];
			OP_UNBLOCK: success = keyMatch
				&& !unblkKeyBlocked[lnk.app];
			default:    success = 1'b0;
		endcase
	end

	assign wrongNow = lnk.req && codeCmd && !match && !blocked[lnk.app];

	// Single-cycle answer
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			lnk.done <= 1'b0;
			lnk.ok   <= 1'b0;
		end
		else
		begin
			lnk.done <= lnk.req;
			lnk.ok   <= lnk.req && success;
		end
	end

	// Stored codes and keys
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < NUM_APPS; i++)
			begin
				storedCode[i] <= CODE_RESET;
				unblkKey[i]   <= UNBLK_RESET;
			end
		end
		else if (lnk.req && lnk.op == OP_CHANGE && success)
			storedCode[lnk.app] <= lnk.newCode;
	end

	// Enabled indicator
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			enabled <= '1;
		else if (lnk.req && success && lnk.op == OP_DISABLE)
			enabled[lnk.app] <= 1'b0;
		else if (lnk.req && success && lnk.op == OP_ENABLE)
			enabled[lnk.app] <= 1'b1;
	end

	// Wrong-presentation counting and blocking
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			blocked <= '0;
			for (int i = 0; i < NUM_APPS; i++)
				wrongCnt[i] <= 2'h0;
		end
		else if (lnk.req)
		begin
			if (wrongNow)
			begin
				wrongCnt[lnk.app] <= wrongCnt[lnk.app] + 2'h1;
				if (wrongCnt[lnk.app] + 2'h1 == MAX_WRONG)
					blocked[lnk.app] <= 1'b1;
			end
			else if (codeCmd && match && !blocked[lnk.app])
				wrongCnt[lnk.app] <= 2'h0;
			else if (lnk.op == OP_UNBLOCK && success)
			begin
				blocked[lnk.app]  <= 1'b0;
				wrongCnt[lnk.app] <= 2'h0;
			end
		end
	end

	// Session access rights
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			right <= '0;
		else if (sessionEnd)
			right <= '0;
		else if (lnk.req && success)
			right[lnk.app] <= 1'b1;
		else if (wrongNow && wrongCnt[lnk.app] + 2'h1 == MAX_WRONG
			&& enabled[lnk.app])
			right[lnk.app] <= 1'b0;
	end

	// State readback for the selected application
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			lnk.stBlocked      <= 1'b0;
			lnk.stEnabled      <= 1'b0;
			lnk.stAllowed      <= 1'b0;
			lnk.stUnblkBlocked <= 1'b0;
			lnk.stRight        <= 1'b0;
		end
		else
		begin
			lnk.stBlocked      <= blocked[lnk.stApp];
			lnk.stEnabled      <= enabled[lnk.stApp];
			lnk.stAllowed      <= ALLOW_ENDIS[lnk.stApp];
			lnk.stUnblkBlocked <= unblkKeyBlocked[lnk.stApp];
			lnk.stRight        <= right[lnk.stApp];
		end
	end
endmodule
`default_nettype wire

// [rtl/parm_term.sv]
// Terminal end: runs code procedures on software command
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module parm_term
	import parm_pkg::*;
	(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              resetn,
	// Software port
	input  wire logic [3:0]        addr,
	input  wire logic [31:0]       wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [31:0]       rdata,
	output logic                   irq,
	// Link to card
	parm_if.term                   lnk
	);
	import parm_pkg::*;

	typedef enum {S_IDLE, S_SETTLE, S_CHECK, S_SEND, S_WAIT} parm_tstate_t;
	parm_tstate_t state;
	parm_op_t     op;
	logic [APP_W-1:0]  app;
	logic [CODE_W-1:0] code;
	logic [CODE_W-1:0] newCode;
	logic resDone;
	logic resOk;
	logic resLocal;
	logic [2:0] irqStat;
	logic [2:0] irqMask;
	logic [2:0] irqSet;
	logic       start;
	logic       localEnd;
	logic       localOk;

	assign start = wr && addr == REG_CMD && state == S_IDLE;

	// Pre-checks decided without invoking the card function
	always_comb
	begin
		localEnd = 1'b0;
		localOk  = 1'b0;
		case (op)
			OP_VERIFY:
			begin
				localEnd = lnk.stBlocked || !lnk.stEnabled;
				localOk  = !lnk.stEnabled;
			end
			OP_CHANGE:
				localEnd = lnk.stBlocked || !lnk.stEnabled;
			OP_DISABLE:
				localEnd = lnk.stBlocked || !lnk.stEnabled
					|| !lnk.stAllowed;
			OP_ENABLE:
				localEnd = lnk.stBlocked || lnk.stEnabled
					|| !lnk.stAllowed;
			OP_UNBLOCK:
				localEnd = lnk.stUnblkBlocked;
			default:
				localEnd = 1'b1;
		endcase
	end

	// Procedure sequencer
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			state <= S_IDLE;
		else
			case (state)
				// Settle lets the state readback follow a new application
				S_IDLE:   if (start) state <= S_SETTLE;
				S_SETTLE: state <= S_CHECK;
				S_CHECK: state <= localEnd ? S_IDLE : S_SEND;
				S_SEND:  state <= S_WAIT;
				S_WAIT:  if (lnk.done) state <= S_IDLE;
				default: state <= S_IDLE;
			endcase
	end

	// Operands from software
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			op      <= OP_NONE;
			app     <= '0;
			code    <= '0;
			newCode <= '0;
		end
		else
		begin
			if (start)
			begin
				op  <= parm_op_t'(wdata[CMD_OP_LSB +: 3]);
				app <= wdata[CMD_APP_LSB +: APP_W];
			end
			if (wr && addr == REG_CODE)
				code <= wdata[CODE_W-1:0];
			if (wr && addr == REG_NEWCODE)
				newCode <= wdata[CODE_W-1:0];
		end
	end

	assign lnk.req     = state == S_SEND;
	assign lnk.op      = op;
	assign lnk.app     = app;
	assign lnk.code    = code;
	assign lnk.newCode = newCode;
	assign lnk.stApp   = app;

	// Result register
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			resDone  <= 1'b0;
			resOk    <= 1'b0;
			resLocal <= 1'b0;
		end
		else if (start)
			resDone <= 1'b0;
		else if (state == S_CHECK && localEnd)
		begin
			resDone  <= 1'b1;
			resOk    <= localOk;
			resLocal <= 1'b1;
		end
		else if (state == S_WAIT && lnk.done)
		begin
			resDone  <= 1'b1;
			resOk    <= lnk.ok;
			resLocal <= 1'b0;
		end
	end

	always_comb
	begin
		irqSet = 3'h0;
		if ((state == S_CHECK && localEnd) || (state == S_WAIT && lnk.done))
		begin
			irqSet[IRQ_DONE] = 1'b1;
			irqSet[IRQ_FAIL] = state == S_CHECK ? !localOk : !lnk.ok;
		end
		if (state == S_WAIT && lnk.done && !lnk.ok && op != OP_UNBLOCK)
			irqSet[IRQ_BLOCK] = 1'b1;
	end

	// Sticky status, cleared by read; a new event wins
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			irqStat <= 3'h0;
		else if (rd && addr == REG_IRQSTAT)
			irqStat <= irqSet;
		else
			irqStat <= irqStat | irqSet;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			irqMask <= 3'h0;
		else if (wr && addr == REG_IRQMASK)
			irqMask <= wdata[2:0];
	end

	assign irq = |(irqStat & irqMask);

	// Read data, one cycle after the strobe
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			rdata <= 32'h0;
		else if (rd)
			case (addr)
				REG_CMD:      rdata <= {26'h0, app, 1'b0, op};
				REG_CODE:     rdata <= code;
				REG_NEWCODE:  rdata <= newCode;
				REG_RESULT:   rdata <= {28'h0, state != S_IDLE,
					resLocal, resOk, resDone};
				REG_IRQSTAT:  rdata <= {29'h0, irqStat};
				REG_IRQMASK:  rdata <= {29'h0, irqMask};
				REG_APPSTATE: rdata <= {27'h0, lnk.stRight,
					lnk.stUnblkBlocked, lnk.stAllowed, lnk.stEnabled,
					lnk.stBlocked};
				default:      rdata <= 32'h0;
			endcase
		else
			rdata <= 32'h0;
	end
endmodule
`default_nettype wire

// [tb/parm_sva.sv]
// Checker of the card link of the secret-code gate
`timescale 1ns/100ps
`default_nettype none
module parm_sva
	(
	// Clock and reset
	input wire logic                     clock,
	input wire logic                     resetn,
	// Terminal requests
	input wire logic                     req,
	input wire parm_pkg::parm_op_t       op,
	input wire logic [parm_pkg::APP_W-1:0] stApp,
	// Card answers and state
	input wire logic                     done,
	input wire logic                     ok,
	input wire logic                     stBlocked,
	input wire logic                     stEnabled,
	input wire logic                     stAllowed,
	input wire logic                     stUnblkBlocked,
	input wire logic                     stRight
	);
	import parm_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_grant; done && ok && $stable(stApp) |=> stRight; endproperty
	property p_none;
		done && !ok && !stRight && $stable(stApp) |=> !stRight;
	endproperty
	property p_block;
		$rose(stBlocked) && $stable(stApp) && $past(stApp) == $past(stApp, 2)
		|-> $past(done) && !$past(ok) && !(stEnabled && stRight);
	endproperty
	property p_forbid;
		!stAllowed && $stable(stApp) && $past(resetn) |=> $stable(stEnabled);
	endproperty
	property p_unblk;
		done && ok && $past(op) == OP_UNBLOCK && $stable(stApp) |=> !stBlocked;
	endproperty
	property p_dis;
		done && ok && $past(op) == OP_DISABLE && $stable(stApp) |=> !stEnabled;
	endproperty
	property p_en;
		done && ok && $past(op) == OP_ENABLE && $stable(stApp) |=> stEnabled;
	endproperty
	property p_ver; req && op == OP_VERIFY |-> !stBlocked && stEnabled; endproperty
	property p_chg; req && op == OP_CHANGE |-> !stBlocked && stEnabled; endproperty
	property p_key; req && op == OP_UNBLOCK |-> !stUnblkBlocked; endproperty
	a_grant: assert property (p_grant)
		else $error("right missing after success");
	a_none: assert property (p_none)
		else $error("right granted after failure");
	a_block: assert property (p_block)
		else $error("bad blocking");
	a_forbid: assert property (p_forbid)
		else $error("forbidden indicator changed");
	a_unblk: assert property (p_unblk)
		else $error("still blocked after unblock");
	a_dis: assert property (p_dis)
		else $error("still enabled after disable");
	a_en: assert property (p_en)
		else $error("still disabled after enable");
	a_ver: assert property (p_ver)
		else $error("verify sent in wrong state");
	a_chg: assert property (p_chg)
		else $error("change sent in wrong state");
	a_key: assert property (p_key)
		else $error("unblock sent with blocked key");
	c_block: cover property ($rose(stBlocked));
	c_fail: cover property (done && !ok);
	c_unblk: cover property (done && ok && $past(op) == OP_UNBLOCK);
endmodule
`default_nettype wire

// [tb/test_pin_access_right_manager.sv]
// Self-checking bench for both ends of the secret-code gate
`timescale 1ns/100ps
`default_nettype none
module test_pin_access_right_manager;
	import parm_pkg::*;
	localparam logic [NUM_APPS-1:0] ALLOWED = 4'hb;
	localparam logic [NUM_APPS-1:0] KEYBLK  = 4'h8;
	logic                clock = 1'b0;
	logic                resetn = 1'b0;
	logic [3:0]          addr = 4'h0;
	logic [31:0]         wdata = 32'h0;
	logic                wr = 1'b0;
	logic                rd = 1'b0;
	logic                sessionEnd = 1'b0;
	logic [31:0]         rdata;
	logic                irq;
	logic [31:0]         got;
	logic [CODE_W-1:0]   mCode [NUM_APPS];
	logic [NUM_APPS-1:0] mEn;
	logic [NUM_APPS-1:0] mBlk;
	logic [NUM_APPS-1:0] mRight;
	int                  mWrong [NUM_APPS];
	int                  error_cnt = 0;
	int                  n_compared = 0;
	parm_if lnk ();
	parm_card #(.ALLOW_ENDIS(ALLOWED)) parm_card_i (.clock(clock),
		.resetn(resetn), .lnk(lnk), .sessionEnd(sessionEnd),
		.unblkKeyBlocked(KEYBLK));
	parm_term parm_term_i (.clock(clock), .resetn(resetn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .lnk(lnk));
	parm_sva parm_sva_i (.clock(clock), .resetn(resetn), .req(lnk.req),
		.op(lnk.op), .stApp(lnk.stApp), .done(lnk.done), .ok(lnk.ok),
		.stBlocked(lnk.stBlocked), .stEnabled(lnk.stEnabled),
		.stAllowed(lnk.stAllowed), .stUnblkBlocked(lnk.stUnblkBlocked),
		.stRight(lnk.stRight));
	always #10 clock = ~clock;
	task automatic give_verdict();
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] exp, input logic [31:0] act);
		n_compared++;
		if (act !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: expected %h got %h", $time, exp, act);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		got = rdata;
	endtask
	// Expected outcome; updates the bench's copy of the card state
	function automatic logic predict(logic [2:0] op, int a, logic [31:0] c,
		logic [31:0] nc);
		if (op == 3'h0 || op > 3'h5)
			return 1'b0;
		if (op == 3'h5)
		begin
			if (KEYBLK[a] || c != UNBLK_RESET)
				return 1'b0;
			mBlk[a] = 1'b0;
			mWrong[a] = 0;
			mRight[a] = 1'b1;
			return 1'b1;
		end
		if (op == 3'h1 && !mEn[a])
			return 1'b1;
		if (mBlk[a] || mEn[a] == (op == 3'h4))
			return 1'b0;
		if (op > 3'h2 && !ALLOWED[a])
			return 1'b0;
		if (c != mCode[a])
		begin
			mWrong[a]++;
			if (mWrong[a] == 3)
			begin
				mBlk[a] = 1'b1;
				if (mEn[a])
					mRight[a] = 1'b0;
			end
			return 1'b0;
		end
		mWrong[a] = 0;
		mRight[a] = 1'b1;
		if (op == 3'h2)
			mCode[a] = nc;
		if (op > 3'h2)
			mEn[a] = (op == 3'h4);
		return 1'b1;
	endfunction
	// Selects the application first so the terminal sees its state
	task automatic run(logic [2:0] op, int a, logic [31:0] c, logic [31:0] nc);
		logic e;
		int n;
		e = predict(op, a, c, nc);
		wreg(REG_CODE, c);
		wreg(REG_NEWCODE, nc);
		for (int k = 0; k < 2; k++)
		begin
			wreg(REG_CMD, {26'h0, a[1:0], 1'b0, k == 1 ? op : 3'h0});
			n = 0;
			do
			begin
				rreg(REG_RESULT);
				n++;
			end while ((got[3] !== 1'b0 || got[0] !== 1'b1) && n < 30);
			if (got[3] !== 1'b0 || got[0] !== 1'b1)
			begin
				error_cnt++;
				give_verdict();
			end
		end
		check({31'h0, e}, {31'h0, got[RES_OK]});
		rreg(REG_APPSTATE);
		check({mRight[a], mEn[a], mBlk[a]}, {got[4], got[1:0]});
	endtask
	initial
	begin
		logic [31:0] bad;
		logic [2:0]  op;
		int          a;
		for (int i = 0; i < NUM_APPS; i++)
		begin
			mCode[i] = CODE_RESET;
			mWrong[i] = 0;
		end
		mEn = '1;
		mBlk = '0;
		mRight = '0;
		void'($urandom(32'h7844));
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		rreg(REG_APPSTATE);
		check(32'h6, got);
		bad = CODE_RESET ^ 32'h80;
		for (int k = 0; k < 6; k++)
		begin
			if (k == 5)
			begin
				@(posedge clock);
				sessionEnd <= 1'b1;
				@(posedge clock);
				sessionEnd <= 1'b0;
				mRight = '0;
			end
			run(3'h1, 0, k == 2 ? CODE_RESET : bad, 0);
		end
		run(3'h1, 0, CODE_RESET, 0);
		run(3'h5, 0, bad, CODE_RESET);
		run(3'h5, 0, UNBLK_RESET, CODE_RESET);
		run(3'h5, 3, UNBLK_RESET, CODE_RESET);
		run(3'h3, 2, CODE_RESET, 0);
		bad = $urandom;
		run(3'h2, 1, bad, bad);
		run(3'h2, 1, CODE_RESET, bad);
		run(3'h1, 1, bad, 0);
		run(3'h3, 1, bad, 0);
		run(3'h3, 1, bad, 0);
		run(3'h1, 1, 0, 0);
		run(3'h4, 1, ~bad, 0);
		run(3'h4, 1, bad, 0);
		run(3'h6, 1, bad, 0);
		rreg(REG_IRQSTAT);
		wreg(REG_IRQMASK, 32'h4);
		check(32'h0, {31'h0, irq});
		run(3'h1, 1, ~bad, 0);
		check(32'h1, {31'h0, irq});
		rreg(REG_IRQSTAT);
		check(32'h7, got);
		check(32'h0, {31'h0, irq});
		rreg(REG_IRQMASK);
		check(32'h4, got);
		for (int i = 0; i < 60; i++)
		begin
			a = $urandom % 2;
			bad = $urandom;
			op = 3'($urandom % 5 + 1);
			run(op, a, $urandom % 2 ? (op == 3'h5 ? UNBLK_RESET : mCode[a]) : bad,
				op == 3'h2 ? bad : mCode[a]);
		end
		rreg(4'hf);
		check(32'h0, got);
		give_verdict();
	end
endmodule
`default_nettype wire
